// file: src/legacy_video_defines.svh
`ifndef LEGACY_VIDEO_DEFINES_SVH
`define LEGACY_VIDEO_DEFINES_SVH

// configuration port shape
`define LV_CFG_ADDR_W 8
`define LV_CFG_DATA_W 16
`define LV_CFG_BE_W 2

// register offsets (16-bit registers on even byte offsets)
`define LV_OFS_REMAP_BASE 8'h98
`define LV_OFS_REMAP_LIMIT 8'h9a

// remap field layout and reset values
`define LV_REMAP_FIELD_W 10
`define LV_REMAP_LSB 26
`define LV_REMAP_BASE_RST 10'h3ff
`define LV_REMAP_LIMIT_RST 10'h000
`define LV_RSVD_W 6
`define LV_BYTE_W 8

// host cycle shape
`define LV_HOST_ADDR_W 36
`define LV_HOST_BE_W 4
`define LV_IO_ALIAS_W 10

// legacy video memory ranges
`define LV_VGA_MEM_LO 36'h0_000a_0000
`define LV_VGA_MEM_HI 36'h0_000b_ffff
`define LV_MONO_MEM_LO 36'h0_000b_0000
`define LV_MONO_MEM_HI 36'h0_000b_7fff

// legacy video i/o ranges, ten address bits decoded (isa aliases)
`define LV_VGA_IO_A_LO 10'h3b0
`define LV_VGA_IO_A_HI 10'h3bb
`define LV_VGA_IO_B_LO 10'h3c0
`define LV_VGA_IO_B_HI 10'h3df

// monochrome adapter i/o locations
`define LV_MONO_IO_0 10'h3b4
`define LV_MONO_IO_1 10'h3b5
`define LV_MONO_IO_2 10'h3b8
`define LV_MONO_IO_3 10'h3b9
`define LV_MONO_IO_4 10'h3ba
`define LV_MONO_IO_5 10'h3bf

`endif

// file: src/legacy_video_pkg.sv
`include "legacy_video_defines.svh"

package legacy_video_pkg;

  // where a decoded cycle goes
  typedef enum logic [1:0] {
    TARGET_NONE,
    TARGET_SOUTH,
    TARGET_GFX
  } route_target_e;

  // which legacy region a cycle hit
  typedef enum logic [1:0] {
    CLASS_OTHER,
    CLASS_VGA,
    CLASS_MONO
  } region_class_e;

  // configuration access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [`LV_CFG_ADDR_W-1:0] addr;
    logic [`LV_CFG_BE_W-1:0] be;
    logic [`LV_CFG_DATA_W-1:0] wdata;
  } cfg_req_s;

  // host memory or i/o cycle to decode
  typedef struct packed {
    logic valid;
    logic is_io;
    logic [`LV_HOST_BE_W-1:0] be;
    logic [`LV_HOST_ADDR_W-1:0] addr;
  } host_cycle_s;

  // decode result
  typedef struct packed {
    logic valid;
    logic is_io;
    route_target_e target;
    region_class_e cls;
    logic in_remap;
  } route_s;

endpackage

// file: src/addr_range_match.sv
`timescale 1ns/1ps

// inclusive range compare: lo <= addr <= hi
module addr_range_match #(
  parameter int W = 36
) (
  // operands
  input wire logic [W-1:0] i_addr,
  input wire logic [W-1:0] i_lo,
  input wire logic [W-1:0] i_hi,
  // result
  output logic o_hit
);

  // both bounds belong to the range
  assign o_hit = (i_addr >= i_lo) && (i_addr <= i_hi);

endmodule

// file: src/legacy_video_decode.sv
`timescale 1ns/1ps
`include "legacy_video_defines.svh"

// Notes on behaviour
// - routing and mono-present clear: all mono and vga references go south
// - routing on, mono absent: vga and mono references go to graphics port
// - both set: vga to graphics port, mono references to south link
// - memory cycles cross the graphics port only with memory access enabled
// - i/o cycles cross the graphics port only with i/o access enabled
// - remap base: ten rw bits of address 35:26, reset all ones
// - remap base is the inclusive lower window bound
// - base compare assumes address bits 25:0 zero, 64 MB aligned bottom
// - window disabled while base exceeds limit
// - remap limit: ten rw bits of address 35:26, reset zero
// - remap limit is the inclusive upper window bound
// - limit compare assumes address bits 25:0 ones, top just below a 64 MB boundary
module legacy_video_decode #(
  parameter int ADDR_W = `LV_HOST_ADDR_W,
  parameter int FIELD_W = `LV_REMAP_FIELD_W
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // configuration register port
  input wire legacy_video_pkg::cfg_req_s i_cfg_req,
  output logic [`LV_CFG_DATA_W-1:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  output logic o_cfg_hit,
  // routing control bits held elsewhere in the hub
  input wire logic i_legacy_video_route_en,
  input wire logic i_mono_adapter_present,
  input wire logic i_port_mem_access_en,
  input wire logic i_port_io_access_en,
  // host cycle in, decision out
  input wire legacy_video_pkg::host_cycle_s i_cycle,
  output legacy_video_pkg::route_s o_route,
  // remap window state
  output logic [FIELD_W-1:0] o_remap_base,
  output logic [FIELD_W-1:0] o_remap_limit,
  output logic o_remap_en,
  output logic o_route_cfg_invalid
);

  localparam int LSB = `LV_REMAP_LSB;
  localparam int IOW = `LV_IO_ALIAS_W;
  localparam int NBE = `LV_HOST_BE_W;
  localparam int BW = `LV_BYTE_W;
  // word numbers of the two registers, as addr[7:1] shows them
  localparam logic [`LV_CFG_ADDR_W-2:0] BASE_WORD =
    (`LV_CFG_ADDR_W-1)'(`LV_OFS_REMAP_BASE >> 1);
  localparam logic [`LV_CFG_ADDR_W-2:0] LIMIT_WORD =
    (`LV_CFG_ADDR_W-1)'(`LV_OFS_REMAP_LIMIT >> 1);

  logic [FIELD_W-1:0] base_reg;
  logic [FIELD_W-1:0] base_next;
  logic [FIELD_W-1:0] limit_reg;
  logic [FIELD_W-1:0] limit_next;
  logic [`LV_CFG_DATA_W-1:0] rdata_reg;
  logic [`LV_CFG_DATA_W-1:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic hit_reg;
  logic hit_next;
  legacy_video_pkg::route_s route_reg;
  legacy_video_pkg::route_s route_next;
  logic remap_en_reg;
  logic remap_en_next;
  logic cfg_invalid_reg;
  logic cfg_invalid_next;

  logic sel_base;
  logic sel_limit;
  logic remap_en;
  logic remap_hit;
  logic vga_mem_hit;
  logic mono_mem_hit;
  logic [NBE-1:0] vga_io_a_hit;
  logic [NBE-1:0] vga_io_b_hit;
  logic [NBE-1:0] mono_io_hit;
  logic vga_io_any;
  logic mono_io_any;
  logic [ADDR_W-1:0] win_lo;
  logic [ADDR_W-1:0] win_hi;

  // word decode: a 16-bit register sits on an even byte offset
  assign sel_base = i_cfg_req.addr[`LV_CFG_ADDR_W-1:1] == BASE_WORD;
  assign sel_limit = i_cfg_req.addr[`LV_CFG_ADDR_W-1:1] == LIMIT_WORD;

  // register writes; reserved bits 15:10 are dropped on write
  always_comb begin
    base_next = base_reg;
    limit_next = limit_reg;
    if (i_cfg_req.wr && sel_base) begin
      if (i_cfg_req.be[0]) begin
        base_next[BW-1:0] = i_cfg_req.wdata[BW-1:0];
      end
      if (i_cfg_req.be[1]) begin
        base_next[FIELD_W-1:BW] = i_cfg_req.wdata[FIELD_W-1:BW];
      end
    end
    if (i_cfg_req.wr && sel_limit) begin
      if (i_cfg_req.be[0]) begin
        limit_next[BW-1:0] = i_cfg_req.wdata[BW-1:0];
      end
      if (i_cfg_req.be[1]) begin
        limit_next[FIELD_W-1:BW] = i_cfg_req.wdata[FIELD_W-1:BW];
      end
    end
  end

  // bit 0 is stored as written; keeping it zero is software's duty
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      base_reg <= `LV_REMAP_BASE_RST;
      limit_reg <= `LV_REMAP_LIMIT_RST;
    end else begin
      base_reg <= base_next;
      limit_reg <= limit_next;
    end
  end

  // read path: one cycle latency, unmapped offsets read zero with no hit
  always_comb begin
    rdata_next = '0;
    rvalid_next = i_cfg_req.rd;
    hit_next = 1'b0;
    if (i_cfg_req.rd) begin
      hit_next = sel_base || sel_limit;
      if (sel_base) begin
        rdata_next = {{`LV_RSVD_W{1'b0}}, base_reg};
      end else if (sel_limit) begin
        rdata_next = {{`LV_RSVD_W{1'b0}}, limit_reg};
      end
      // byte lanes not enabled return zero
      if (!i_cfg_req.be[0]) begin
        rdata_next[BW-1:0] = '0;
      end
      if (!i_cfg_req.be[1]) begin
        rdata_next[`LV_CFG_DATA_W-1:BW] = '0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      hit_reg <= hit_next;
    end
  end

  // window bounds widened to full addresses
  assign win_lo = {base_reg, {LSB{1'b0}}};
  assign win_hi = {limit_reg, {LSB{1'b1}}};
  // an inverted pair turns the window off rather than wrapping; the
  // enable is taken from the next values so it never lags a write
  always_comb begin
    remap_en_next = base_next <= limit_next;
    cfg_invalid_next = i_mono_adapter_present &&
                       !i_legacy_video_route_en;
  end

  // window enable and configuration error flag held in flip-flops
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      remap_en_reg <= (`LV_REMAP_BASE_RST <= `LV_REMAP_LIMIT_RST);
      cfg_invalid_reg <= 1'b0;
    end else begin
      remap_en_reg <= remap_en_next;
      cfg_invalid_reg <= cfg_invalid_next;
    end
  end

  assign remap_en = remap_en_reg;

  // inclusive at both ends
  addr_range_match #(.W(ADDR_W)) u_remap (
    .i_addr(i_cycle.addr),
    .i_lo(win_lo),
    .i_hi(win_hi),
    .o_hit(remap_hit)
  );

  // legacy frame buffer ranges
  addr_range_match #(.W(ADDR_W)) u_vga_mem (
    .i_addr(i_cycle.addr),
    .i_lo(`LV_VGA_MEM_LO),
    .i_hi(`LV_VGA_MEM_HI),
    .o_hit(vga_mem_hit)
  );

  addr_range_match #(.W(ADDR_W)) u_mono_mem (
    .i_addr(i_cycle.addr),
    .i_lo(`LV_MONO_MEM_LO),
    .i_hi(`LV_MONO_MEM_HI),
    .o_hit(mono_mem_hit)
  );

  // i/o decode per enabled byte; only ten address bits count, so
  // every isa alias of a legacy port decodes the same way
  genvar gb;
  generate
    for (gb = 0; gb < NBE; gb++) begin : g_io_byte
      logic [IOW-1:0] io_addr;
      assign io_addr = {i_cycle.addr[IOW-1:2], 2'(gb)};
      addr_range_match #(.W(IOW)) u_vga_io_a (
        .i_addr(io_addr),
        .i_lo(`LV_VGA_IO_A_LO),
        .i_hi(`LV_VGA_IO_A_HI),
        .o_hit(vga_io_a_hit[gb])
      );
      addr_range_match #(.W(IOW)) u_vga_io_b (
        .i_addr(io_addr),
        .i_lo(`LV_VGA_IO_B_LO),
        .i_hi(`LV_VGA_IO_B_HI),
        .o_hit(vga_io_b_hit[gb])
      );
      assign mono_io_hit[gb] = i_cycle.be[gb] &&
                               ((io_addr == `LV_MONO_IO_0) ||
                                (io_addr == `LV_MONO_IO_1) ||
                                (io_addr == `LV_MONO_IO_2) ||
                                (io_addr == `LV_MONO_IO_3) ||
                                (io_addr == `LV_MONO_IO_4) ||
                                (io_addr == `LV_MONO_IO_5));
    end
  endgenerate

  // one mono byte claims the whole access, even mixed with others
  assign mono_io_any = |mono_io_hit;
  assign vga_io_any = |((vga_io_a_hit | vga_io_b_hit) & i_cycle.be);

  // routing decision, registered so the result is glitch free
  always_comb begin
    route_next = '0;
    route_next.valid = i_cycle.valid;
    route_next.is_io = i_cycle.is_io;
    route_next.target = legacy_video_pkg::TARGET_NONE;
    route_next.cls = legacy_video_pkg::CLASS_OTHER;
    route_next.in_remap = 1'b0;
    if (i_cycle.valid) begin
      // remap only concerns memory cycles
      route_next.in_remap = !i_cycle.is_io && remap_en && remap_hit;
      if (i_cycle.is_io) begin
        if (mono_io_any) begin
          route_next.cls = legacy_video_pkg::CLASS_MONO;
        end else if (vga_io_any) begin
          route_next.cls = legacy_video_pkg::CLASS_VGA;
        end
      end else begin
        if (mono_mem_hit) begin
          route_next.cls = legacy_video_pkg::CLASS_MONO;
        end else if (vga_mem_hit) begin
          route_next.cls = legacy_video_pkg::CLASS_VGA;
        end
      end
      case (route_next.cls)
        legacy_video_pkg::CLASS_VGA: begin
          // vga follows the routing enable alone
          if (i_legacy_video_route_en) begin
            route_next.target = legacy_video_pkg::TARGET_GFX;
          end else begin
            route_next.target = legacy_video_pkg::TARGET_SOUTH;
          end
        end
        legacy_video_pkg::CLASS_MONO: begin
          // mono-present with routing off is treated as all-south
          if (i_legacy_video_route_en && !i_mono_adapter_present) begin
            route_next.target = legacy_video_pkg::TARGET_GFX;
          end else begin
            route_next.target = legacy_video_pkg::TARGET_SOUTH;
          end
        end
        default: begin
          route_next.target = legacy_video_pkg::TARGET_NONE;
        end
      endcase
      // a disabled port space falls back to the south link
      if (route_next.target == legacy_video_pkg::TARGET_GFX) begin
        if (!i_cycle.is_io && !i_port_mem_access_en) begin
          route_next.target = legacy_video_pkg::TARGET_SOUTH;
        end
        if (i_cycle.is_io && !i_port_io_access_en) begin
          route_next.target = legacy_video_pkg::TARGET_SOUTH;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      route_reg <= '0;
    end else begin
      route_reg <= route_next;
    end
  end

  // outputs
  assign o_cfg_rdata = rdata_reg;
  assign o_cfg_rvalid = rvalid_reg;
  assign o_cfg_hit = hit_reg;
  assign o_route = route_reg;
  assign o_remap_base = base_reg;
  assign o_remap_limit = limit_reg;
  assign o_remap_en = remap_en;
  // flags the combination software must avoid, one cycle after it appears
  assign o_route_cfg_invalid = cfg_invalid_reg;

endmodule

// file: dv/legacy_video_assertions.sv
`timescale 1ns/1ps
// watches the decoder from its ports only
module legacy_video_checker #(
  parameter int ADDR_W = 36,
  parameter int FIELD_W = 10
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // register port
  input wire legacy_video_pkg::cfg_req_s i_cfg_req,
  input wire logic [15:0] o_cfg_rdata,
  input wire logic o_cfg_rvalid,
  // routing controls
  input wire logic i_legacy_video_route_en,
  input wire logic i_mono_adapter_present,
  input wire logic i_port_mem_access_en,
  input wire logic i_port_io_access_en,
  // decode
  input wire legacy_video_pkg::host_cycle_s i_cycle,
  input wire legacy_video_pkg::route_s o_route,
  input wire logic [FIELD_W-1:0] o_remap_base,
  input wire logic [FIELD_W-1:0] o_remap_limit,
  input wire logic o_remap_en
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  logic win;
  logic mem;
  logic gfx;
  // expected window hit, bounds padded to 64 MB granules
  assign win = o_remap_en && i_cycle.addr >= {o_remap_base, 26'h000_0000}
    && i_cycle.addr <= {o_remap_limit, 26'h3ff_ffff};
  assign mem = i_cycle.valid && !i_cycle.is_io;
  assign gfx = o_route.target == legacy_video_pkg::TARGET_GFX;
  sequence s_rd_base;
    i_cfg_req.rd && i_cfg_req.addr[7:1] == 7'h4c;
  endsequence
  sequence s_wr(logic [6:0] w);
    i_cfg_req.wr && i_cfg_req.addr[7:1] == w && i_cfg_req.be == 2'h3;
  endsequence
  property p_rd;
    s_rd_base |=> o_cfg_rvalid && o_cfg_rdata ==
      ({6'h00, $past(o_remap_base)} & {{8{$past(i_cfg_req.be[1])}},
      {8{$past(i_cfg_req.be[0])}}});
  endproperty
  a_rd: assert property (p_rd) else $error("base read mismatch");
  property p_wr_lim;
    s_wr(7'h4d) |=> o_remap_limit == $past(i_cfg_req.wdata[9:0]);
  endproperty
  a_wr_lim: assert property (p_wr_lim) else $error("limit write lost");
  property p_en;
    o_remap_en == (o_remap_base <= o_remap_limit);
  endproperty
  a_en: assert property (p_en) else $error("window enable wrong");
  property p_win;
    mem |=> o_route.in_remap == $past(win);
  endproperty
  a_win: assert property (p_win) else $error("remap hit");
  property p_mem_gate;
    mem && !i_port_mem_access_en |=> !gfx;
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("mem gate");
  property p_io_gate;
    i_cycle.valid && i_cycle.is_io && !i_port_io_access_en |=> !gfx;
  endproperty
  a_io_gate: assert property (p_io_gate) else $error("io gate");
  property p_off;
    i_cycle.valid && !i_legacy_video_route_en |=> !gfx;
  endproperty
  a_off: assert property (p_off) else $error("routing off");
  property p_gfx;
    mem && i_legacy_video_route_en && !i_mono_adapter_present &&
      i_port_mem_access_en |=> gfx ||
      o_route.cls == legacy_video_pkg::CLASS_OTHER;
  endproperty
  a_gfx: assert property (p_gfx) else $error("legacy not on port");
  property p_mono;
    i_cycle.valid && i_legacy_video_route_en && i_mono_adapter_present
      |=> !gfx || o_route.cls != legacy_video_pkg::CLASS_MONO;
  endproperty
  a_mono: assert property (p_mono) else $error("mono not south");
endmodule

bind legacy_video_decode legacy_video_checker #(
  .ADDR_W(ADDR_W), .FIELD_W(FIELD_W)
) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_cfg_req(i_cfg_req),
  .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
  .i_legacy_video_route_en(i_legacy_video_route_en),
  .i_mono_adapter_present(i_mono_adapter_present),
  .i_port_mem_access_en(i_port_mem_access_en),
  .i_port_io_access_en(i_port_io_access_en), .i_cycle(i_cycle),
  .o_route(o_route), .o_remap_base(o_remap_base),
  .o_remap_limit(o_remap_limit), .o_remap_en(o_remap_en)
);

// file: dv/host_cpu_model.sv
`timescale 1ns/1ps
// host processor stand-in: one cycle per call
module host_cpu_model (
  // clock
  input wire logic i_ref_clk,
  // cycle to the decoder
  output legacy_video_pkg::host_cycle_s o_cycle
);
  initial o_cycle = '0;
  // released bus shows the inverted address so stale values never match
  task automatic issue(input logic io, input logic [35:0] a);
    @(posedge i_ref_clk);
    o_cycle <= {1'b1, io, 4'h1, a};
    @(posedge i_ref_clk);
    o_cycle <= {1'b0, io, 4'h1, ~a};
  endtask
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  legacy_video_pkg::cfg_req_s req = '0;
  logic re = 1'b0;
  logic mp = 1'b0;
  logic me = 1'b1;
  logic ie = 1'b1;
  logic [15:0] rdata;
  logic rvalid;
  logic hit;
  logic en;
  logic [9:0] bs;
  logic [9:0] lm;
  logic inv;
  legacy_video_pkg::host_cycle_s cyc;
  legacy_video_pkg::route_s rt;
  int bad_count = 0;
  int total_checks = 0;
  // 50 MHz clock
  always #10 i_ref_clk = ~i_ref_clk;
  host_cpu_model u_cpu (.i_ref_clk(i_ref_clk), .o_cycle(cyc));
  legacy_video_decode u_dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_cfg_req(req),
    .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .o_cfg_hit(hit),
    .i_legacy_video_route_en(re), .i_mono_adapter_present(mp),
    .i_port_mem_access_en(me), .i_port_io_access_en(ie), .i_cycle(cyc),
    .o_route(rt), .o_remap_base(bs), .o_remap_limit(lm), .o_remap_en(en),
    .o_route_cfg_invalid(inv)
  );
  task automatic chk(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one-cycle register strobes, both byte lanes
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, be: 2'h3, wdata: d};
    @(posedge i_ref_clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic h);
    @(posedge i_ref_clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, be: 2'h3, wdata: 16'h0000};
    @(posedge i_ref_clk);
    req <= '0;
    #1;
    chk("rdata", rdata, e);
    chk("flags", {14'h0000, rvalid, hit}, {14'h0000, 1'b1, h});
  endtask
  // answer is due exactly one edge after the cycle is taken
  task automatic dec(input logic io, input logic [35:0] a, input logic [1:0] t,
                     input logic [1:0] c, input logic r);
    u_cpu.issue(io, a);
    #1;
    chk("route", {9'h000, rt}, {9'h000, 1'b1, io, t, c, r});
  endtask
  task automatic ctl(input logic [3:0] v);
    @(posedge i_ref_clk);
    {re, mp, me, ie} <= v;
  endtask
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
  // encodings: 1 south, 2 port; classes 1 vga, 2 mono
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    rd(8'h98, 16'h03ff, 1'b1);
    rd(8'h9a, 16'h0000, 1'b1);
    rd(8'h9c, 16'h0000, 1'b0);
    chk("en", {15'h0000, en}, 16'h0000);
    chk("base", {6'h00, bs}, 16'h03ff);
    chk("limit", {6'h00, lm}, 16'h0000);
    // combination 0/1 is never set by software
    for (int k = 0; k < 3; k++) begin
      ctl({k != 0, k == 2, 2'b11});
      dec(1'b0, 36'h0_000a_0000, k ? 2'h2 : 2'h1, 2'h1, 1'b0);
      dec(1'b0, 36'h0_000b_0000, k == 1 ? 2'h2 : 2'h1, 2'h2, 1'b0);
      dec(1'b1, 36'h0_0000_03c0, k ? 2'h2 : 2'h1, 2'h1, 1'b0);
      dec(1'b1, 36'h0_0000_03b4, k == 1 ? 2'h2 : 2'h1, 2'h2, 1'b0);
      chk("cfg_invalid", {15'h0000, inv}, 16'h0000);
    end
    ctl(4'b1001);
    dec(1'b0, 36'h0_000a_0000, 2'h1, 2'h1, 1'b0);
    dec(1'b1, 36'h0_0000_03c0, 2'h2, 2'h1, 1'b0);
    ctl(4'b1010);
    dec(1'b1, 36'h0_0000_03c0, 2'h1, 2'h1, 1'b0);
    dec(1'b0, 36'h0_000a_0000, 2'h2, 2'h1, 1'b0);
    // reserved bits are dropped; base bit 0 kept clear by software
    wr(8'h98, 16'hfc02);
    rd(8'h98, 16'h0002, 1'b1);
    wr(8'h9a, 16'h0004);
    #1;
    chk("limit", {6'h00, lm}, 16'h0004);
    chk("en", {15'h0000, en}, 16'h0001);
    dec(1'b0, 36'h0_07ff_ffff, 2'h0, 2'h0, 1'b0);
    dec(1'b0, 36'h0_0800_0000, 2'h0, 2'h0, 1'b1);
    dec(1'b0, 36'h0_13ff_ffff, 2'h0, 2'h0, 1'b1);
    dec(1'b0, 36'h0_1400_0000, 2'h0, 2'h0, 1'b0);
    wr(8'h98, 16'h0006);
    dec(1'b0, 36'h0_1800_0000, 2'h0, 2'h0, 1'b0);
    wr(8'h98, 16'h0004);
    dec(1'b0, 36'h0_1000_0000, 2'h0, 2'h0, 1'b1);
    // mid-run reset must bring both bounds back to their reset values
    @(posedge i_ref_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    #1;
    chk("base", {6'h00, bs}, 16'h03ff);
    chk("limit", {6'h00, lm}, 16'h0000);
    chk("en", {15'h0000, en}, 16'h0000);
    rd(8'h98, 16'h03ff, 1'b1);
    rd(8'h9a, 16'h0000, 1'b1);
    close_out();
  end
endmodule
